// >>> hw/sw_bits_pkg.sv
// constants for the status word flag control register
package sw_bits_pkg;
  // host register decode
  localparam logic [15:0] FLAG_REG_ADDR = 16'h0007;
  localparam logic [15:0] FLAG_REG_RESET = 16'h0000;
  // bits the host may set: 15, 9, 8, 3, 2, 0
  localparam logic [15:0] FLAG_WR_MASK = 16'h830d;
  // bits that feed the status word
  localparam logic [15:0] FLAG_SW_MASK = 16'h030d;
  // register bit positions
  localparam int B_SEND_ONCE = 15;
  localparam int B_RX_ERR = 10;
  localparam int B_TELEM = 9;
  localparam int B_SVC_REQ = 8;
  localparam int B_BCAST = 4;
  localparam int B_BUSY = 3;
  localparam int B_SUB_FAULT = 2;
  localparam int B_DYN_BUS = 1;
  localparam int B_TERM_FLAG = 0;
  // status word rt address field
  localparam int RT_ADDR_LSB = 11;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } sw_state_t;
endpackage

// >>> hw/rt_status_word_bits.sv
// status word flag register and status word assembly for the remote terminal
// How it works
// - 16-bit host register at 0x0007; set bits go into each status word
// - dynamic bus control acceptance bit is always sent as zero
// - host flags repeat in every status word until host clears them
// - broadcast-received and message-error positions come from device inputs
// - register bits 4 and 10 ignore writes and read zero
// - with send-once bit set, whole register clears after a word is sent
// - transmit status or last command mode codes repeat previously sent flags
// - unused bits 14-10, 7-4 and 1 cannot be set, read zero
// - bit 9 set gives the instrumentation status bit
// - bit 8 set gives the service request status bit
// - bit 3 set gives busy on every valid command
// - descriptor busy bit gives busy for that command alone
// - busy response sends status only, data words suppressed
// - busy message sets busy history flag in its message info word
// - subsystem flag is register bit 2 or the external pin
// - vector word command clears bit 2 before status sent, option zero
// - bit 0 set gives the terminal flag status bit
// - master or software reset clears every defined bit
module rt_status_word_bits
  import sw_bits_pkg::*;
(
  // clock and resets
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic soft_reset,
  // host register access
  input wire logic [15:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  // status request and command qualifiers from the protocol engine
  input wire logic [4:0] rt_address,
  input wire logic status_req,
  input wire logic cmd_is_repeat_mc,
  input wire logic cmd_is_vector_mc,
  input wire logic desc_busy,
  // device-owned flags and the subsystem pin
  input wire logic broadcast_received_flag,
  input wire logic rx_error_flag,
  input wire logic sub_fault_pin,
  input wire logic vector_clear_option_cfg,
  input wire logic status_sent,
  // latched status word and response qualifiers
  output logic [15:0] status_word,
  output logic status_valid,
  output logic suppress_data,
  output logic busy_history_flag
);
  import sw_bits_pkg::*;

  sw_state_t state;
  sw_state_t next_state;
  logic [15:0] flag_reg;
  logic [15:0] next_flag_reg;
  logic [15:0] last_flags;

  ////////////////////////////////////////////////////////////////
  // decode
  wire reg_hit = host_addr == FLAG_REG_ADDR;
  wire wr_hit = host_wr && reg_hit;
  wire rd_hit = host_rd && reg_hit;
  // requests only reach an idle sequencer, ends only a holding one
  wire req_take = status_req && state == ST_IDLE;
  wire sent_take = status_sent && state == ST_HOLD;
  // automatic clears; vector clear acts at the request, before the word leaves
  wire vec_clear = req_take && cmd_is_vector_mc && !vector_clear_option_cfg;
  wire once_clear = sent_take && flag_reg[B_SEND_ONCE];
  // host data with the unsettable bits forced low
  wire [15:0] wr_val = host_wdata & FLAG_WR_MASK;
  wire [15:0] vec_mask = vec_clear ? ~(16'h0001 << B_SUB_FAULT) : 16'hffff;

  // register next value: reset, host write, automatic clears
  always_comb begin
    next_flag_reg = flag_reg;
    if (once_clear) begin
      next_flag_reg = ZERO_WORD;
    end
    if (wr_hit) begin
      next_flag_reg = wr_val;
    end
    next_flag_reg = next_flag_reg & vec_mask;
  end

  ////////////////////////////////////////////////////////////////
  // status word assembly, from register with vector clear applied
  wire [15:0] cur_flags = flag_reg & vec_mask & FLAG_SW_MASK;
  wire [15:0] use_flags = cmd_is_repeat_mc ? (cur_flags | last_flags) : cur_flags;
  wire word_busy = use_flags[B_BUSY] | desc_busy;
  wire word_ssf = use_flags[B_SUB_FAULT] | sub_fault_pin;
  wire [15:0] word_rt = 16'(rt_address) << RT_ADDR_LSB;
  wire [15:0] word_dev = (16'(rx_error_flag) << B_RX_ERR) |
                         (16'(broadcast_received_flag) << B_BCAST);
  wire [15:0] word_host = (16'(use_flags[B_TELEM]) << B_TELEM) |
                          (16'(use_flags[B_SVC_REQ]) << B_SVC_REQ) |
                          (16'(word_busy) << B_BUSY) |
                          (16'(word_ssf) << B_SUB_FAULT) |
                          (16'(use_flags[B_TERM_FLAG]) << B_TERM_FLAG);
  wire [15:0] next_word = word_rt | word_dev | word_host;

  // sequencer: word is latched on request and held until sent
  always_comb begin
    case (state)
      ST_IDLE: next_state = status_req ? ST_HOLD : ST_IDLE;
      ST_HOLD: next_state = status_sent ? ST_IDLE : ST_HOLD;
      default: next_state = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // register and sequencer state
  always_ff @(posedge clk_sys) begin
    if (rst || soft_reset) begin
      flag_reg <= FLAG_REG_RESET;
      state <= ST_IDLE;
      last_flags <= ZERO_WORD;
    end else begin
      flag_reg <= next_flag_reg;
      state <= next_state;
      if (sent_take) begin
        last_flags <= status_word & FLAG_SW_MASK;
      end
    end
  end

  // latched status word, frozen while held
  always_ff @(posedge clk_sys) begin
    if (rst || soft_reset) begin
      status_word <= ZERO_WORD;
      status_valid <= 1'b0;
      suppress_data <= 1'b0;
      busy_history_flag <= 1'b0;
    end else if (req_take) begin
      status_word <= next_word;
      status_valid <= 1'b1;
      suppress_data <= word_busy;
      busy_history_flag <= word_busy;
    end else if (sent_take) begin
      status_valid <= 1'b0;
    end
  end

  // host read port, zero when unmapped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      host_rdata <= ZERO_WORD;
    end else begin
      host_rdata <= rd_hit ? flag_reg : ZERO_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst || soft_reset);

  chk_dyn_bus_zero: assert property (status_valid |-> !status_word[B_DYN_BUS])
    else $error("dynamic bus control bit set");
  chk_unused_zero: assert property ((flag_reg & ~FLAG_WR_MASK) == ZERO_WORD)
    else $error("unused register bit set");
  chk_busy_suppress: assert property (status_valid |-> suppress_data == status_word[B_BUSY])
    else $error("busy and suppress differ");
  chk_busy_hist: assert property (status_valid |-> busy_history_flag == suppress_data)
    else $error("busy history mismatch");
  chk_global_busy: assert property (req_take && flag_reg[B_BUSY] |=> status_word[B_BUSY])
    else $error("global busy not sent");
  chk_desc_busy: assert property (req_take && desc_busy |=> status_word[B_BUSY])
    else $error("descriptor busy not sent");
  chk_subsys_or: assert property (req_take && sub_fault_pin |=> status_word[B_SUB_FAULT])
    else $error("subsystem pin not sent");
  chk_vector_clear: assert property (vec_clear && !wr_hit |=> !flag_reg[B_SUB_FAULT])
    else $error("vector clear missed");
  chk_once_clear: assert property (once_clear && !wr_hit |=> flag_reg == ZERO_WORD)
    else $error("send once clear missed");
  chk_word_frozen: assert property (status_valid && !sent_take |=> $stable(status_word))
    else $error("status word changed in flight");
  chk_telem_sent: assert property (req_take && flag_reg[B_TELEM] |=> status_word[B_TELEM])
    else $error("telemetry bit not sent");

  ////////////////////////////////////////////////////////////////
  // word fields, sequencer, host port and register behaviour

  // rt address field follows the address pins at the request
  chk_rt_addr_sent: assert property (
    req_take |=> (status_word >> RT_ADDR_LSB) == 16'($past(rt_address)))
    else $error("rt address field wrong");

  // a taken request raises valid on the next cycle
  chk_valid_rise: assert property (
    req_take |=> status_valid)
    else $error("status valid not raised");

  // the end of transmission drops valid
  chk_valid_fall: assert property (
    sent_take |=> !status_valid)
    else $error("status valid not dropped");

  // valid stands exactly while the sequencer holds
  chk_valid_state: assert property (
    status_valid == (state == ST_HOLD))
    else $error("valid and sequencer disagree");

  // sequencer state stays one-hot
  chk_state_onehot: assert property (
    $onehot(state))
    else $error("sequencer state not one-hot");

  // the word keeps its value once sent
  chk_word_after_sent: assert property (
    sent_take |=> $stable(status_word))
    else $error("status word changed at end");

  // service request flag reaches the word
  chk_svc_req_sent: assert property (
    req_take && flag_reg[B_SVC_REQ] |=> status_word[B_SVC_REQ])
    else $error("service request bit not sent");

  // terminal flag reaches the word
  chk_term_flag_sent: assert property (
    req_take && flag_reg[B_TERM_FLAG] |=> status_word[B_TERM_FLAG])
    else $error("terminal flag bit not sent");

  // broadcast position follows the device flag, not the register
  chk_bcast_follow: assert property (
    req_take |=> status_word[B_BCAST] == $past(broadcast_received_flag))
    else $error("broadcast bit wrong");

  // message error position follows the device flag, not the register
  chk_rx_err_follow: assert property (
    req_take |=> status_word[B_RX_ERR] == $past(rx_error_flag))
    else $error("message error bit wrong");

  // a read of the register returns its value
  chk_rd_hit_value: assert property (
    rd_hit |=> host_rdata == $past(flag_reg))
    else $error("register read wrong");

  // no read or another address gives zero
  chk_rd_miss_zero: assert property (
    !rd_hit |=> host_rdata == ZERO_WORD)
    else $error("read data not zero");

  // unsettable and device-owned bits read zero
  chk_rd_unused_zero: assert property (
    rd_hit |=> (host_rdata & ~FLAG_WR_MASK) == ZERO_WORD)
    else $error("unused bit read back set");

  // a host write lands masked
  chk_write_lands: assert property (
    wr_hit && !vec_clear |=> flag_reg == ($past(host_wdata) & FLAG_WR_MASK))
    else $error("host write not taken");

  // without write or clear the flags stay put
  chk_flag_hold: assert property (
    !wr_hit && !once_clear && !vec_clear |=> $stable(flag_reg))
    else $error("register changed on its own");

  // with send-once off a sent word leaves the flags set
  chk_once_off_keep: assert property (
    sent_take && !flag_reg[B_SEND_ONCE] && !wr_hit |=> $stable(flag_reg))
    else $error("flags cleared without send-once");

  // no busy source, no suppression
  chk_busy_cause: assert property (
    req_take && !flag_reg[B_BUSY] && !desc_busy && !cmd_is_repeat_mc |=> !suppress_data)
    else $error("data suppressed without busy");

  // descriptor busy marks the message info word
  chk_hist_desc: assert property (
    req_take && desc_busy |=> busy_history_flag)
    else $error("busy history not set");

  // no busy source, no busy history
  chk_hist_clear: assert property (
    req_take && !flag_reg[B_BUSY] && !desc_busy && !cmd_is_repeat_mc |=> !busy_history_flag)
    else $error("busy history set without busy");

  // repeat mode codes still carry the previously sent flags
  chk_repeat_carry: assert property (
    req_take && cmd_is_repeat_mc |=> ($past(last_flags) & ~status_word) == ZERO_WORD)
    else $error("previous flags not repeated");

  // vector word response already has the register flag cleared
  chk_vec_word_clear: assert property (
    vec_clear && !sub_fault_pin && !cmd_is_repeat_mc |=> !status_word[B_SUB_FAULT])
    else $error("subsystem flag sent after clear");

  // subsystem flag needs the register bit or the pin
  chk_ssf_source: assert property (
    req_take && !flag_reg[B_SUB_FAULT] && !sub_fault_pin && !cmd_is_repeat_mc
      |=> !status_word[B_SUB_FAULT])
    else $error("subsystem flag without source");

  // register subsystem flag reaches the word when not cleared
  chk_reg_ssf_sent: assert property (
    req_take && flag_reg[B_SUB_FAULT] && !vec_clear |=> status_word[B_SUB_FAULT])
    else $error("register subsystem flag not sent");

  // either reset clears the register and the response
  chk_reset_clear: assert property (@(posedge clk_sys) disable iff (1'b0)
    (rst || soft_reset) |=> flag_reg == FLAG_REG_RESET && !status_valid)
    else $error("reset did not clear");

  // main scenarios
  cov_busy_resp: cover property (req_take ##1 suppress_data ##[1:20] sent_take);
  cov_once_then_repeat: cover property (once_clear ##[1:20] (req_take && cmd_is_repeat_mc));
  cov_vector_clear: cover property (vec_clear ##1 status_word[B_SUB_FAULT] == 1'b0);
  // host write while a word is held
  cov_write_in_flight: cover property (status_valid && wr_hit);
  // repeat mode code with flags to carry
  cov_repeat_carry: cover property (req_take && cmd_is_repeat_mc && last_flags != ZERO_WORD);
endmodule

// >>> verif/bc_model.sv
// bus controller model taking status words
module bc_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic go,
  input wire logic [3:0] gap,
  input wire logic status_valid,
  output logic status_req = 1'b0,
  output logic status_sent = 1'b0,
  output logic idle = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt = 4'h0;
  // ask for a word, hold the line gap cycles, then end it
  always @(posedge clk_sys) begin
    status_req <= 1'b0;
    status_sent <= 1'b0;
    if (rst || status_sent) begin
      idle <= 1'b1;
    end else if (idle && go) begin
      status_req <= 1'b1;
      idle <= 1'b0;
      cnt <= gap;
    end else if (!idle && status_valid && !status_req) begin
      if (cnt == 4'h0) status_sent <= 1'b1;
      cnt <= cnt - 4'h1;
    end
  end
endmodule

// >>> verif/tb_top.sv
// self-checking bench for the status word flag register
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sw_bits_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, soft_reset = 1'b0, host_wr = 1'b0, host_rd = 1'b0, go = 1'b0;
  logic [15:0] host_addr = FLAG_REG_ADDR, host_wdata = 16'h0000, host_rdata, status_word;
  logic [4:0] rt_address = 5'h00;
  logic [3:0] gap = 4'h0;
  logic cmd_is_repeat_mc = 1'b0, cmd_is_vector_mc = 1'b0, desc_busy = 1'b0, sub_fault_pin = 1'b0;
  logic broadcast_received_flag = 1'b0, rx_error_flag = 1'b0, vector_clear_option_cfg = 1'b0;
  logic status_req, status_sent, idle, status_valid, suppress_data, busy_history_flag, b;
  logic [15:0] shadow = 16'h0000, last_flags = 16'h0000, flags;
  int error_cnt = 0, tests_run = 0, cyc = 0, i;
  always #50 clk_sys = ~clk_sys;
  rt_status_word_bits uut (.clk_sys, .rst, .soft_reset, .host_addr, .host_wr, .host_rd,
    .host_wdata, .host_rdata, .rt_address, .status_req, .cmd_is_repeat_mc, .cmd_is_vector_mc,
    .desc_busy, .broadcast_received_flag, .rx_error_flag, .sub_fault_pin,
    .vector_clear_option_cfg, .status_sent, .status_word, .status_valid, .suppress_data,
    .busy_history_flag);
  bc_model bc (.clk_sys, .rst, .go, .gap, .status_valid, .status_req, .status_sent, .idle);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // cut a hang short
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  task automatic wr(input logic [15:0] d);
    @(posedge clk_sys);
    host_wr <= 1'b1;
    host_wdata <= d;
    @(posedge clk_sys);
    host_wr <= 1'b0;
    shadow = d & FLAG_WR_MASK;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge clk_sys);
    host_rd <= 1'b0;
    host_addr <= FLAG_REG_ADDR;
    @(negedge clk_sys);
  endtask
  // expected word from register flags and device inputs
  function automatic logic [15:0] exp_word(input logic [15:0] f);
    return {rt_address, rx_error_flag, f[9], f[8], 3'b000, broadcast_received_flag,
      f[3] | desc_busy, f[2] | sub_fault_pin, 1'b0, f[0]};
  endfunction
  // one status transfer through the model, then check the register
  task automatic xfer(input logic [15:0] mid, input bit mid_on);
    @(posedge clk_sys);
    go <= 1'b1;
    // vector clear hits the register before repeat flags are merged
    if (cmd_is_vector_mc && !vector_clear_option_cfg) shadow[B_SUB_FAULT] = 1'b0;
    flags = cmd_is_repeat_mc ? (shadow | last_flags) : shadow;
    b = flags[B_BUSY] | desc_busy;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk(status_word, exp_word(flags));
    chk({15'h0, suppress_data}, {15'h0, b});
    chk({15'h0, busy_history_flag}, {15'h0, b});
    chk({15'h0, status_valid}, 16'h0001);
    // repeat mode codes echo the sent word, busy and pin included
    last_flags = exp_word(flags) & FLAG_SW_MASK;
    // a write while the word is held leaves that word alone
    if (mid_on) begin
      wr(mid);
      @(negedge clk_sys);
      chk(status_word, exp_word(flags));
    end
    if (shadow[B_SEND_ONCE]) shadow = ZERO_WORD;
    for (i = 0; i < 40 && !idle; i++) @(posedge clk_sys);
    chk({15'h0, status_valid}, 16'h0000);
    rd(FLAG_REG_ADDR);
    chk(host_rdata, shadow);
  endtask
  // reset, corner cases, then random traffic
  initial begin
    void'($urandom(75));
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rd(FLAG_REG_ADDR);
    chk(host_rdata, FLAG_REG_RESET);
    wr(16'hffff);
    rd(FLAG_REG_ADDR);
    chk(host_rdata, 16'h830d);
    rd(16'h0008);
    chk(host_rdata, ZERO_WORD);
    repeat (80) begin
      wr(16'($urandom));
      {rt_address, broadcast_received_flag, rx_error_flag, sub_fault_pin} <= 8'($urandom);
      {desc_busy, vector_clear_option_cfg, gap, cmd_is_repeat_mc} <= 7'($urandom);
      cmd_is_vector_mc <= 1'($urandom);
      xfer(16'h0000, 1'b0);
    end
    // host write lands while the word is held, send-once then clears it
    gap <= 4'hf;
    xfer(16'h8301, 1'b1);
    wr(16'h830d);
    @(posedge clk_sys);
    soft_reset <= 1'b1;
    @(posedge clk_sys);
    soft_reset <= 1'b0;
    rd(FLAG_REG_ADDR);
    chk(host_rdata, ZERO_WORD);
    results();
  end
endmodule
